/* rtl/bcfgl_loader.sv */
// Purpose: Serial loader of override and boost settings for four equalizer channels.
// Assumes: Serial pins are sampled by hclk; serial clock well below hclk/6.
// Notes: Registers are reached over AHB-Lite with one wait state per transfer.
`timescale 1ns/1ps
module bcfgl_loader
	import bcfgl_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial configuration link
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic load_enable_n,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	// Boost control
	input wire logic [BOOST_ALL_W-1:0] boost_select_pins,
	output logic [BOOST_ALL_W-1:0] boost_level,
	output logic override_active
);

	// Synchronised pin levels
	logic sclk_s;
	logic sdi_s;
	logic en_n_s;
	logic [BOOST_ALL_W-1:0] pins_s;

	// Edge history
	logic sclk_d_r;
	logic en_n_d_r;
	logic sclk_rise;
	logic en_fall;
	logic en_rise;
	logic shift_go;

	// Shadow and active storage
	logic [SHADOW_LEN-1:0] shadow_r;
	logic [SHADOW_LEN-1:0] shadow_nxt;
	logic [SHADOW_LEN-1:0] active_r;
	logic [BOOST_ALL_W-1:0] boost_nxt;

	// Transaction status
	logic [CNT_W-1:0] bit_cnt_r;
	logic over_r;
	logic short_r;
	logic done_r;

	// Software control
	logic ctrl_out_en_r;
	logic ctrl_hold_r;

	// Bus state
	logic dp_pend_r;
	logic dp_write_r;
	logic [ADDR_DEC_W-1:0] dp_addr_r;
	logic addr_accept;
	logic [31:0] rd_mux;

	bcfgl_sync3 #(
		.WIDTH(1),
		.INIT(1'b0)
	) u_sync_sclk (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(serial_clk),
		.level_out(sclk_s)
	);

	bcfgl_sync3 #(
		.WIDTH(1),
		.INIT(1'b0)
	) u_sync_sdi (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(serial_data_in),
		.level_out(sdi_s)
	);

	// Idle level of the enable is high so reset causes no false latch
	bcfgl_sync3 #(
		.WIDTH(1),
		.INIT(1'b1)
	) u_sync_en (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(load_enable_n),
		.level_out(en_n_s)
	);

	bcfgl_sync3 #(
		.WIDTH(BOOST_ALL_W),
		.INIT('0)
	) u_sync_pins (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(boost_select_pins),
		.level_out(pins_s)
	);

	// Edge history of serial clock and enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_d_r <= 1'b0;
			en_n_d_r <= 1'b1;
		end else begin
			sclk_d_r <= sclk_s;
			en_n_d_r <= en_n_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign en_fall = ~en_n_s & en_n_d_r;
	assign en_rise = en_n_s & ~en_n_d_r;
	assign shift_go = sclk_rise & ~en_n_s;

	// Stage 1 takes the new bit, every stage moves one higher
	assign shadow_nxt = {shadow_r[SHADOW_LEN-2:0], sdi_s};

	// Shadow shift chain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shadow_r <= SHADOW_RST;
		end else if (shift_go) begin
			shadow_r <= shadow_nxt;
		end
	end

	// Out bit taken from stage 20 as it moves into stage 21, registered after the serial edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_data_out <= 1'b0;
		end else if (shift_go) begin
			serial_data_out <= shadow_r[SHADOW_LEN-2];
		end
	end

	// Serial out drive enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_data_out_oe <= 1'b0;
		end else begin
			serial_data_out_oe <= ctrl_out_en_r;
		end
	end

	// Latch shadow into the active settings on enable release, unless the hold bit is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_r <= ACTIVE_RST;
		end else if (en_rise && !ctrl_hold_r) begin
			active_r <= shadow_r;
		end
	end

	// Selection between pins and serial settings, one override bit for all channels
	always_comb begin
		boost_nxt = '0;
		for (int c = 0; c < CHAN_NUM; c++) begin
			if (active_r[OVR_POS]) begin
				boost_nxt[c*BOOST_W +: BOOST_W] = active_r[BOOST_BASE + c*BOOST_W +: BOOST_W];
			end else begin
				boost_nxt[c*BOOST_W +: BOOST_W] = pins_s[c*BOOST_W +: BOOST_W];
			end
		end
	end

	// Applied boost and override state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boost_level <= '0;
			override_active <= 1'b0;
		end else begin
			boost_level <= boost_nxt;
			override_active <= active_r[OVR_POS];
		end
	end

	// Bits clocked in this transaction, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_cnt_r <= '0;
		end else if (en_fall) begin
			bit_cnt_r <= '0;
		end else if (shift_go && bit_cnt_r != CNT_MAX) begin
			bit_cnt_r <= bit_cnt_r + 8'h01;
		end
	end

	// Outcome of the last completed transaction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			over_r <= 1'b0;
			short_r <= 1'b0;
			done_r <= 1'b0;
		end else if (en_rise) begin
			over_r <= (bit_cnt_r > CNT_FULL);
			short_r <= (bit_cnt_r < CNT_FULL);
			done_r <= ~ctrl_hold_r;
		end
	end

	// Address phase accepted
	assign addr_accept = hsel & hready & htrans[1];

	// Data phase bookkeeping, one wait state per transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_pend_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r <= '0;
		end else if (addr_accept) begin
			dp_pend_r <= 1'b1;
			dp_write_r <= hwrite;
			dp_addr_r <= haddr[ADDR_DEC_W-1:0];
		end else begin
			dp_pend_r <= 1'b0;
		end
	end

	// Ready drops for the first data-phase cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= ~addr_accept;
		end
	end

	// Response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= HRESP_OKAY;
		end else begin
			hresp <= HRESP_OKAY;
		end
	end

	// Control register writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_out_en_r <= CTRL_OUT_EN_RST;
			ctrl_hold_r <= CTRL_HOLD_RST;
		end else if (dp_pend_r && dp_write_r && dp_addr_r == OFS_CTRL) begin
			ctrl_out_en_r <= hwdata[CTRL_OUT_EN_POS];
			ctrl_hold_r <= hwdata[CTRL_HOLD_POS];
		end
	end

	// Read multiplexer, unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (dp_addr_r)
			OFS_CTRL: begin
				rd_mux[CTRL_OUT_EN_POS] = ctrl_out_en_r;
				rd_mux[CTRL_HOLD_POS] = ctrl_hold_r;
			end
			OFS_SHADOW: begin
				rd_mux[SHADOW_LEN-1:0] = shadow_r;
			end
			OFS_ACTIVE: begin
				rd_mux[SHADOW_LEN-1:0] = active_r;
			end
			OFS_BOOST: begin
				rd_mux[BOOST_ALL_W-1:0] = boost_level;
			end
			OFS_STATUS: begin
				rd_mux[STAT_LOADING_POS] = ~en_n_s;
				rd_mux[STAT_OVER_POS] = over_r;
				rd_mux[STAT_SHORT_POS] = short_r;
				rd_mux[STAT_DONE_POS] = done_r;
				rd_mux[STAT_CNT_LSB +: CNT_W] = bit_cnt_r;
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	// Read data registered at the end of the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (dp_pend_r && !dp_write_r) begin
			hrdata <= rd_mux;
		end
	end

endmodule : bcfgl_loader

/* rtl/bcfgl_pkg.sv */
// Purpose: Shared constants for the boost configuration shift loader.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes: Offsets are byte addresses.
package bcfgl_pkg;

	// Shadow chain geometry
	localparam int SHADOW_LEN = 21;
	localparam int CHAN_NUM = 4;
	localparam int BOOST_W = 5;
	localparam int BOOST_ALL_W = 20;
	localparam int OVR_POS = 0;
	localparam int BOOST_BASE = 1;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;

	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SHADOW = 8'h04;
	localparam logic [7:0] OFS_ACTIVE = 8'h08;
	localparam logic [7:0] OFS_BOOST = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam int ADDR_DEC_W = 8;

	// Control register fields
	localparam int CTRL_OUT_EN_POS = 0;
	localparam int CTRL_HOLD_POS = 1;

	// Status register fields
	localparam int STAT_LOADING_POS = 0;
	localparam int STAT_OVER_POS = 1;
	localparam int STAT_SHORT_POS = 2;
	localparam int STAT_DONE_POS = 3;
	localparam int STAT_CNT_LSB = 8;
	localparam int CNT_W = 8;

	// Values after reset, and bit count limits
	localparam logic CTRL_OUT_EN_RST = 1'b1;
	localparam logic CTRL_HOLD_RST = 1'b0;
	localparam logic [20:0] SHADOW_RST = 21'h000000;
	localparam logic [20:0] ACTIVE_RST = 21'h000000;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_FULL = 8'h15;

	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage : bcfgl_pkg

/* rtl/bcfgl_sync3.sv */
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
module bcfgl_sync3 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous level in
	input wire logic [WIDTH-1:0] async_in,
	// Filtered level out
	output logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// Synchroniser chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Accept a bit only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_out <= INIT;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					level_out[i] <= s3_r[i];
				end
			end
		end
	end

endmodule : bcfgl_sync3

/* verification/bcfgl_loader_asserts.sv */
// Purpose: Port checks for the boost configuration loader.
// Assumes: hready tied to hreadyout; pins steady during frames.
// Notes: One clock domain.
`timescale 1ns/1ps
module bcfgl_loader_asserts
	import bcfgl_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Link and boost
	input wire logic serial_clk,
	input wire logic load_enable_n,
	input wire logic serial_data_out,
	input wire logic [BOOST_ALL_W-1:0] boost_select_pins,
	input wire logic [BOOST_ALL_W-1:0] boost_level,
	input wire logic override_active
);
	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);
	hresp_okay_a: assert property (hresp == HRESP_OKAY) else $error("hresp bad");
	wait_state_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("wait state bad");
	ready_pulse_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
	rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("hrdata moved");
	pin_boost_a: assert property (
		(!override_active && $stable(boost_select_pins))[*8] |-> boost_level == boost_select_pins)
		else $error("pin boost bad");
	shadow_quiet_a: assert property (
		(!load_enable_n)[*8] |-> $stable(override_active) && $stable(boost_level))
		else $error("applied early");
	sdo_change_a: assert property ((!serial_clk)[*4] |-> $stable(serial_data_out))
		else $error("sdo moved");
	latch_high_a: assert property ($changed(override_active) |-> load_enable_n)
		else $error("latch while low");
endmodule : bcfgl_loader_asserts

/* verification/bcfgl_ctrl_model.sv */
// Purpose: Board controller driving the serial load link.
// Assumes: Serial clock period 200 ns.
// Notes: Clock rests low between frames.
`timescale 1ns/1ps
module bcfgl_ctrl_model (
	// Serial link
	output logic serial_clk,
	output logic serial_data_in,
	output logic load_enable_n
);
	initial begin
		serial_clk = 1'b0;
		serial_data_in = 1'b0;
		load_enable_n = 1'b1;
	end
	task automatic start;
		#3;
		load_enable_n = 1'b0;
		#100;
	endtask : start
	task automatic shift(input logic b);
		serial_data_in = b;
		#80;
		serial_clk = 1'b1;
		#80;
		serial_clk = 1'b0;
		#40;
	endtask : shift
	task automatic stop;
		#100;
		load_enable_n = 1'b1;
		serial_data_in = ~serial_data_in;
		#200;
	endtask : stop
endmodule : bcfgl_ctrl_model

/* verification/bcfgl_loader_test.sv */
// Purpose: Bench for the boost configuration loader.
// Assumes: hready tied to hreadyout.
// Notes: Expected link values come from a local shift model.
`timescale 1ns/1ps
module bcfgl_loader_test
	import bcfgl_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [19:0] boost_select_pins = 20'h9C2E7;
	logic hreadyout, hresp, serial_clk, serial_data_in, load_enable_n;
	logic serial_data_out, serial_data_out_oe, override_active;
	logic [31:0] hrdata, rdat;
	logic [19:0] boost_level;
	logic [20:0] sh = '0;
	logic [20:0] act = '0;
	int mismatches = 0;
	int compares = 0;
	always #10 hclk = ~hclk;
	bcfgl_loader bcfgl_loader_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_clk,
		.serial_data_in, .load_enable_n, .serial_data_out, .serial_data_out_oe,
		.boost_select_pins, .boost_level, .override_active);
	bcfgl_ctrl_model bcfgl_ctrl_model_inst (.serial_clk, .serial_data_in, .load_enable_n);
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			mismatches++;
			conclude();
		end
	endtask : wait_rdy
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= 32'(a);
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rdat = hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h0);
		check(what, rdat, e);
	endtask : rd
	task automatic frame(input logic [63:0] w, input int n);
		bcfgl_ctrl_model_inst.start();
		for (int i = n - 1; i >= 0; i--) begin
			bcfgl_ctrl_model_inst.shift(w[i]);
			sh = {sh[19:0], w[i]};
			check("sdo", 32'(serial_data_out), 32'(sh[20]));
		end
		rd(OFS_ACTIVE, 32'(act), "active early");
		bcfgl_ctrl_model_inst.stop();
	endtask : frame
	task automatic latched;
		rd(OFS_ACTIVE, 32'(act), "active");
		check("override", 32'(override_active), 32'(act[0]));
		check("boost", 32'(boost_level), act[0] ? 32'(act[20:1]) : 32'(boost_select_pins));
	endtask : latched
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		rd(OFS_CTRL, 32'h1, "ctrl");
		check("oe", 32'(serial_data_out_oe), 32'h1);
		rd(8'h20, 32'h0, "unmapped");
		latched();
		frame(64'h15A3C7, 21);
		act = sh;
		latched();
		rd(OFS_STATUS, 32'h1508, "status");
		boost_select_pins <= 20'h3B16D;
		frame(64'h01F0E4B6, 25);
		act = sh;
		rd(OFS_SHADOW, 32'h10E4B6, "shadow");
		latched();
		rd(OFS_STATUS, 32'h190A, "status");
		bus(1'b1, OFS_CTRL, 32'h2);
		rd(OFS_CTRL, 32'h2, "ctrl");
		check("oe", 32'(serial_data_out_oe), 32'h0);
		frame(64'h0F0F0F, 21);
		latched();
		bus(1'b1, OFS_CTRL, 32'h1);
		frame(64'h5, 3);
		act = sh;
		latched();
		rd(OFS_STATUS, 32'h030C, "status");
		frame(64'h3A5B6C7D8E9, 42);
		act = sh;
		latched();
		rd(OFS_STATUS, 32'h2A0A, "status");
		conclude();
	end
endmodule : bcfgl_loader_test
bind bcfgl_loader bcfgl_loader_asserts bcfgl_loader_asserts_inst (.hclk, .hresetn, .hsel,
	.htrans, .hready, .hreadyout, .hresp, .hrdata, .serial_clk, .load_enable_n,
	.serial_data_out, .boost_select_pins, .boost_level, .override_active);
